// *** rtl/pwm_pkg.sv ***
// Package for the pulse-width modulation unit: register map, field layout,
// widths and the packed carriers shared by the unit and its comparator.
// Assumes a single 40 MHz clock domain and a simple word register port.
package pwm_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int CMP_W = 16;
  localparam int CNT_W = CMP_W + 15;
  localparam int NCMP = 4;
  localparam int ADDR_W = 6;
  localparam int SCALE_W = 4;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [ADDR_W-1:0] OFS_CFG = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_SCALED = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_CMP0 = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_CMP1 = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_CMP2 = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_CMP3 = 6'h2C;

  // ==========================================================================
  // Configuration layout and reset values
  // ==========================================================================
  // Writable bits of the configuration word; every other bit is reserved.
  localparam logic [31:0] CFG_WMASK = 32'hFF0F370F;
  localparam logic [31:0] CFG_RST = 32'h00000000;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;
  localparam logic [CNT_W-1:0] COUNT_ZERO = 31'h00000000;
  localparam logic [CNT_W-1:0] COUNT_ONE = 31'h00000001;
  localparam logic [CMP_W-1:0] CMP_RST = 16'h0000;
  localparam logic [5:0] SLICE_BASE = 6'h10;

  typedef struct packed {
    logic [3:0] compare_pending;
    logic [3:0] pair_outputs;
    logic [3:0] rsv_hi;
    logic [3:0] center_align;
    logic [1:0] rsv_mid;
    logic en_oneshot;
    logic en_always;
    logic rsv_lo;
    logic deglitch;
    logic zero_cmp;
    logic sticky;
    logic [3:0] rsv_scale;
    logic [SCALE_W-1:0] scale;
  } cfg_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } reg_rsp_t;

endpackage : pwm_pkg

// *** rtl/pwm_compare_slice.sv ***
// One comparator of the modulation unit: optional fold of the scaled count
// for center alignment, then a greater-or-equal test against its value.
// Assumes the scaled count and compare value come from the same clock.
`timescale 1ns/1ps
module pwm_compare_slice (
  input wire logic [pwm_pkg::CMP_W-1:0] scaled,
  input wire logic [pwm_pkg::CMP_W-1:0] value,
  input wire logic center,
  output logic fire
);
  import pwm_pkg::*;

  logic [CMP_W-1:0] folded;

  // ==========================================================================
  // Compare
  // ==========================================================================
  always_comb begin
    folded = scaled;
    if (center && scaled[CMP_W-1]) begin // [R20]
      folded = ~scaled;
    end
    fire = (folded >= value); // [R11] [R18]
  end

endmodule : pwm_compare_slice

// *** rtl/pwm_counter_compare_unit.sv ***
// Pulse-width modulation unit: counter, scaler, four comparators, pending
// bits with deglitch, sticky and ganging, and the word register port.
// Assumes a requester on the same clock that holds one request per cycle.
//
// Contract
// R01 - Counter steps by one per clock only while some enable is active.
// R02 - Continuous-run enable bit 12 keeps the counter stepping every cycle.
// R03 - One-shot enable bit 13 counts; hardware clears it on counter reset.
// R04 - Software may set one-shot again anytime to replay one period.
// R05 - Reset clears both enable bits so the counter stands still.
// R06 - Scale field bits 3:0 picks where the scaled count starts.
// R07 - Scale 0 takes low bits; scale 15 divides rate by 2^15.
// R08 - With auto-zero bit 9, counter clears the cycle after comparator zero.
// R09 - Auto-zero ends period at reach-or-exceed; otherwise counter wraps.
// R10 - Scaled count register at 0x10 returns the slice in bits 15:0.
// R11 - Each comparator is high when scaled count is at least its value.
// R12 - Deglitch bit 10 holds a captured pending bit high within a period.
// R13 - While deglitching, pending bits drop only at the period start.
// R14 - Deglitch plus auto-zero makes pending bit zero last one cycle.
// R15 - Deglitch without auto-zero uses the all-ones carry as boundary.
// R16 - Sticky bit 8 keeps set pending bits from clearing.
// R17 - Pending bits drive the waveform outputs toward the pads.
// R18 - Short period: value 0 gives full duty, above period gives none.
// R19 - Counter is fifteen bits wider than comparators; upper bits read 0.
// R20 - Center bits 16-19 fold the scaled count when its top bit is set.
// R21 - Gang bits 24-27: own firing raises output, next comparator clears.
// R22 - Configuration writes can clear pending bits 28-31, unless sticky.
// R23 - Reserved bits read as zero and ignore writes.
`timescale 1ns/1ps
module pwm_counter_compare_unit (
  input wire logic ref_clk,
  input wire logic rst,
  input wire pwm_pkg::reg_req_t reg_req,
  output pwm_pkg::reg_rsp_t reg_rsp,
  output logic [pwm_pkg::NCMP-1:0] waveform_output
);
  import pwm_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  cfg_t cfg_q;
  cfg_t cfg_d;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [CMP_W-1:0] cmp_q [NCMP];
  logic [NCMP-1:0] pend_q;
  logic [NCMP-1:0] pend_d;
  logic start_q;
  reg_rsp_t rsp_q;

  logic counting;
  logic period_end;
  logic carry_out;
  logic [CMP_W-1:0] scaled;
  logic [NCMP-1:0] fire;
  logic [NCMP-1:0] fire_gang;
  logic [31:0] slice_mask;
  logic [31:0] shifted;
  logic wr_cfg;
  logic wr_count;
  logic wr_scaled;
  logic rd_req;
  logic [CNT_W-1:0] scaled_wr_value;

  // ==========================================================================
  // Register port decode
  // ==========================================================================
  assign wr_cfg = reg_req.valid && reg_req.write && reg_req.addr == OFS_CFG;
  assign wr_count = reg_req.valid && reg_req.write &&
                    reg_req.addr == OFS_COUNT;
  assign wr_scaled = reg_req.valid && reg_req.write &&
                     reg_req.addr == OFS_SCALED;
  assign rd_req = reg_req.valid && !reg_req.write;

  // A write of the scaled count places the value at the scale position and
  // zeroes the rest of the counter, so the period restarts cleanly.
  assign scaled_wr_value = CNT_W'({16'h0000, reg_req.wdata[CMP_W-1:0]}
                                  << cfg_q.scale);

  // ==========================================================================
  // Scaler and period boundary
  // ==========================================================================
  always_comb begin
    shifted = 32'({1'b0, count_q} >> cfg_q.scale); // [R06] [R07]
    scaled = shifted[CMP_W-1:0];
    // Mask covers counter bits up to the top of the scaled slice; at scale
    // 15 the shift reaches bit 31 and the mask is 0x7FFFFFFF, all 31 counter bits.
    slice_mask = (32'h00000001 << (6'(cfg_q.scale) + SLICE_BASE)) -
                 32'h00000001;
    carry_out = &({1'b0, count_q} | ~slice_mask); // [R15]
  end

  assign counting = cfg_q.en_always || cfg_q.en_oneshot; // [R01]

  // Auto-zero ends the period on reach-or-exceed; otherwise the natural
  // wrap of the scaled count does.
  assign period_end = counting &&
                      (cfg_q.zero_cmp ? fire[0] : carry_out); // [R09] [R15]

  // ==========================================================================
  // Comparators
  // ==========================================================================
  for (genvar i = 0; i < NCMP; i++) begin : g_cmp
    pwm_compare_slice u_slice (
      .scaled(scaled),
      .value(cmp_q[i]),
      .center(cfg_q.center_align[i]),
      .fire(fire[i])
    );
    // The neighbour wraps from the last comparator back to the first.
    assign fire_gang[i] = fire[i] &&
      !(cfg_q.pair_outputs[i] && fire[(i + 1) % NCMP]); // [R21]
  end

  // ==========================================================================
  // Counter
  // ==========================================================================
  always_comb begin
    count_d = count_q;
    if (wr_count) begin
      count_d = reg_req.wdata[CNT_W-1:0]; // [R19]
    end else if (wr_scaled) begin
      count_d = scaled_wr_value;
    end else if (period_end && cfg_q.zero_cmp) begin
      count_d = COUNT_ZERO; // [R08]
    end else if (counting) begin
      count_d = count_q + COUNT_ONE; // [R01] [R02] [R09]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_q <= COUNT_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

  // ==========================================================================
  // Configuration
  // ==========================================================================
  always_comb begin
    cfg_d = cfg_q;
    if (period_end) begin
      cfg_d.en_oneshot = 1'b0; // [R03]
    end
    if (wr_cfg) begin
      // A software write wins over the hardware clear so a re-arm made in
      // the boundary cycle is not lost.
      cfg_d = cfg_t'(reg_req.wdata & CFG_WMASK); // [R04] [R23]
    end
    cfg_d.compare_pending = pend_d;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_q <= cfg_t'(CFG_RST); // [R05]
    end else begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < NCMP; i++) begin
        cmp_q[i] <= CMP_RST;
      end
    end else if (reg_req.valid && reg_req.write) begin
      unique case (reg_req.addr)
        OFS_CMP0: cmp_q[0] <= reg_req.wdata[CMP_W-1:0];
        OFS_CMP1: cmp_q[1] <= reg_req.wdata[CMP_W-1:0];
        OFS_CMP2: cmp_q[2] <= reg_req.wdata[CMP_W-1:0];
        OFS_CMP3: cmp_q[3] <= reg_req.wdata[CMP_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Pending bits
  // ==========================================================================
  // The boundary is registered so the pending bits see the new period one
  // cycle after the match, which also makes pending zero a single pulse.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      start_q <= 1'b0;
    end else begin
      start_q <= period_end; // [R13] [R14]
    end
  end

  always_comb begin
    pend_d = fire_gang; // [R11] [R21]
    if (wr_cfg) begin
      pend_d = pend_d | reg_req.wdata[31:28]; // [R22]
    end else if (cfg_q.deglitch && !start_q) begin
      pend_d = pend_d | pend_q; // [R12] [R13]
    end
    if (cfg_q.sticky) begin
      pend_d = pend_d | pend_q; // [R16]
    end
  end

  assign pend_q = cfg_q.compare_pending;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      waveform_output <= '0;
    end else begin
      waveform_output <= pend_d; // [R17]
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= rd_req;
      rsp_q.rdata <= WORD_ZERO;
      if (rd_req) begin
        unique case (reg_req.addr)
          OFS_CFG: rsp_q.rdata <= 32'(cfg_q); // [R23]
          OFS_COUNT: rsp_q.rdata <= {1'b0, count_q}; // [R19]
          OFS_SCALED: rsp_q.rdata <= {16'h0000, scaled}; // [R10]
          OFS_CMP0: rsp_q.rdata <= {16'h0000, cmp_q[0]};
          OFS_CMP1: rsp_q.rdata <= {16'h0000, cmp_q[1]};
          OFS_CMP2: rsp_q.rdata <= {16'h0000, cmp_q[2]};
          OFS_CMP3: rsp_q.rdata <= {16'h0000, cmp_q[3]};
          default: rsp_q.rdata <= WORD_ZERO;
        endcase
      end
    end
  end

  assign reg_rsp = rsp_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_count_step: assert property ( // [R01]
    counting && !period_end && !wr_count && !wr_scaled
    |=> count_q == $past(count_q) + COUNT_ONE)
    else $error("counter did not step by one while enabled");

  a_count_hold: assert property ( // [R01]
    !counting && !wr_count && !wr_scaled |=> count_q == $past(count_q))
    else $error("counter moved while no enable was active");

  a_always_runs: assert property ( // [R02]
    cfg_q.en_always && !cfg_q.zero_cmp && !wr_cfg && !wr_count &&
    !wr_scaled |=> count_q != $past(count_q))
    else $error("continuous run failed to advance the counter");

  a_oneshot_clear: assert property ( // [R03]
    period_end && !wr_cfg |=> !cfg_q.en_oneshot)
    else $error("one-shot enable survived the counter reset");

  a_reset_stop: assert property (@(posedge ref_clk) disable iff (1'b0)
    rst |=> !cfg_q.en_always && !cfg_q.en_oneshot) // [R05]
    else $error("enables not cleared by reset");

  a_zero_clear: assert property ( // [R08]
    cfg_q.zero_cmp && counting && fire[0] && !wr_count && !wr_scaled
    |=> count_q == COUNT_ZERO)
    else $error("auto-zero did not clear the counter");

  a_scaled_slice: assert property ( // [R10]
    rd_req && reg_req.addr == OFS_SCALED
    |=> reg_rsp.valid && reg_rsp.rdata[31:16] == 16'h0000 &&
        reg_rsp.rdata[15:0] == CMP_W'($past(count_q) >> $past(cfg_q.scale)))
    else $error("scaled count read does not match counter slice");

  a_pend_glitch: assert property ( // [R12]
    cfg_q.deglitch && pend_q[1] && !start_q && !wr_cfg |=> pend_q[1])
    else $error("deglitched pending bit fell inside a period");

  a_sticky_hold: assert property ( // [R16]
    cfg_q.sticky && pend_q[2] |=> pend_q[2])
    else $error("sticky pending bit cleared");

  a_wave_follow: assert property ( // [R17]
    ##1 waveform_output == pend_q)
    else $error("waveform output differs from pending bits");

  a_gang_clear: assert property ( // [R21]
    cfg_q.pair_outputs[0] && fire[1] && !cfg_q.deglitch &&
    !cfg_q.sticky && !wr_cfg |=> !pend_q[0])
    else $error("ganged output not cleared by the next comparator");

endmodule : pwm_counter_compare_unit

// *** tb/sw_host.sv ***
// Software side of the register port: issues single word reads and writes.
// Assumes requests launch on the falling edge and answers come one cycle on.
`timescale 1ns/1ps
module sw_host (
  input wire logic ref_clk,
  input wire pwm_pkg::reg_rsp_t reg_rsp,
  output pwm_pkg::reg_req_t reg_req
);
  import pwm_pkg::*;

  initial begin
    reg_req = '0;
  end

  // An idle bus drops valid and shows the inverse of its last address and data, so a design that
  // samples it outside a request cannot pass by luck.
  task automatic release_bus();
    reg_req.valid = 1'b0;
    reg_req.addr = ~reg_req.addr;
    reg_req.wdata = ~reg_req.wdata;
  endtask : release_bus

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    reg_req.valid = 1'b1;
    reg_req.write = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    @(posedge ref_clk);
    @(negedge ref_clk);
    release_bus();
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                    output logic ok);
    @(negedge ref_clk);
    reg_req.valid = 1'b1;
    reg_req.write = 1'b0;
    reg_req.addr = a;
    @(posedge ref_clk);
    @(negedge ref_clk);
    ok = reg_rsp.valid;
    d = reg_rsp.rdata;
    release_bus();
  endtask : rd
endmodule : sw_host

// *** tb/tb_top.sv ***
// Self-checking bench for the modulation unit, one task per scenario.
// Assumes the unit answers reads on the taking edge, half a cycle before the host samples.
`timescale 1ns/1ps
module tb_top;
  import pwm_pkg::*;
  logic ref_clk;
  logic rst;
  reg_req_t reg_req;
  reg_rsp_t reg_rsp;
  logic [NCMP-1:0] waveform_output;
  int errors;
  int n_tests;
  logic [31:0] rd_d;
  logic [31:0] rd_e;
  logic rd_ok;

  sw_host host (.ref_clk(ref_clk), .reg_rsp(reg_rsp), .reg_req(reg_req));

  pwm_counter_compare_unit dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_req(reg_req),
    .reg_rsp(reg_rsp),
    .waveform_output(waveform_output)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Checking helpers
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    host.rd(a, rd_d, rd_ok);
    chk({31'h0, rd_ok}, 32'h1);
    chk(rd_d, e);
  endtask : rd_chk

  task automatic test_done();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // Counts high cycles per output over len cycles; -1 skips a bit.
  task automatic wave(input int e[4], input int len);
    int n[4];
    n = '{0, 0, 0, 0};
    repeat (len) begin
      @(negedge ref_clk);
      for (int i = 0; i < 4; i++) begin
        if (waveform_output[i] === 1'b1) n[i]++;
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (e[i] >= 0) chk(32'(n[i]), 32'(e[i]));
    end
  endtask : wave

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Compare values reset to zero, so every comparator fires at count zero
  // and its pending bit is set on the first rising edge after reset falls.
  task automatic t_reset();
    rd_chk(OFS_CFG, 32'hF0000000);
    repeat (5) @(negedge ref_clk);
    rd_chk(OFS_COUNT, WORD_ZERO);
    chk(32'(waveform_output), 32'h0000000F);
  endtask : t_reset

  task automatic t_reserved();
    host.wr(OFS_CFG, ~CFG_WMASK);
    rd_chk(OFS_CFG, 32'hF0000000);
    host.wr(6'h04, 32'hFFFFFFFF);
    rd_chk(6'h04, WORD_ZERO);
    host.wr(OFS_CMP2, 32'hFFFFFFFF);
    rd_chk(OFS_CMP2, 32'h0000FFFF);
    host.wr(OFS_COUNT, 32'hFFFFFFFF);
    rd_chk(OFS_COUNT, 32'h7FFFFFFF);
  endtask : t_reserved

  task automatic t_scale();
    logic [3:0] sc[3] = '{4'h0, 4'h4, 4'hF};
    logic [31:0] ex[3] = '{32'h0000DEF0, 32'h0000CDEF, 32'h0000F579};
    host.wr(OFS_COUNT, 32'h7ABCDEF0);
    for (int i = 0; i < 3; i++) begin
      host.wr(OFS_CFG, {28'h0, sc[i]});
      rd_chk(OFS_SCALED, ex[i]);
    end
  endtask : t_scale

  task automatic t_count();
    logic [31:0] a;
    host.wr(OFS_COUNT, WORD_ZERO);
    host.wr(OFS_CFG, 32'h00001000);
    host.rd(OFS_COUNT, a, rd_ok);
    host.rd(OFS_COUNT, rd_d, rd_ok);
    chk(rd_d - a, 32'h2);
    host.wr(OFS_CFG, WORD_ZERO);
    host.rd(OFS_COUNT, a, rd_ok);
    repeat (3) @(negedge ref_clk);
    host.rd(OFS_COUNT, rd_d, rd_ok);
    chk(rd_d - a, WORD_ZERO);
  endtask : t_count

  // Period of 7 cycles set by comparator zero; 1 gives full duty, 2 none.
  task automatic t_wave();
    logic [31:0] cf[4] = '{32'h1200, 32'h1600, 32'h08001200, 32'h1300};
    int ex[4][4] = '{'{2, 14, 0, 8}, '{2, -1, 0, -1}, '{2, 14, 0, 6},
                     '{14, 14, 0, 14}};
    host.wr(OFS_CMP0, 32'h6);
    host.wr(OFS_CMP1, WORD_ZERO);
    host.wr(OFS_CMP2, 32'h7);
    host.wr(OFS_CMP3, 32'h3);
    host.wr(OFS_COUNT, WORD_ZERO);
    for (int i = 0; i < 4; i++) begin
      host.wr(OFS_CFG, cf[i]);
      repeat (16) @(negedge ref_clk);
      wave(ex[i], 14);
    end
  endtask : t_wave

  task automatic t_clear();
    host.wr(OFS_CFG, 32'h00000100);
    rd_chk(OFS_CFG, 32'hB0000100);
    host.wr(OFS_COUNT, 32'h1);
    host.wr(OFS_CFG, WORD_ZERO);
    rd_chk(OFS_CFG, 32'h20000000);
  endtask : t_clear

  task automatic t_oneshot();
    host.wr(OFS_COUNT, WORD_ZERO);
    host.wr(OFS_CFG, 32'h2200);
    repeat (20) @(negedge ref_clk);
    rd_chk(OFS_CFG, 32'h20000200);
    rd_chk(OFS_COUNT, WORD_ZERO);
    host.wr(OFS_CFG, 32'h2200);
    wave('{1, -1, 0, -1}, 20);
  endtask : t_oneshot

  // A folded count of 0x0FFF stays below 0x9000, the plain 0xF000 does not.
  task automatic t_center();
    host.wr(OFS_CMP2, 32'h00009000);
    host.wr(OFS_COUNT, 32'h0000F000);
    host.wr(OFS_CFG, 32'h00040000);
    rd_chk(OFS_CFG, 32'hB0040000);
  endtask : t_center

  // ==========================================================================
  // Main sequence and hang guard
  // ==========================================================================
  initial begin
    errors = 0;
    n_tests = 0;
    rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    t_reset();
    t_reserved();
    t_scale();
    t_count();
    t_wave();
    t_clear();
    t_oneshot();
    t_center();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    test_done();
  end
endmodule : tb_top
